// *** pwm_bridge.v ***
// enhanced bridge pwm output stage with wishbone register slave
`timescale 1ns/10ps
`include "pwm_bridge_defines.vh"

// Operation
// RL1 - two-bit config selects single, half, full forward or full reverse
// RL2 - 10-bit modulated signal presented on up to four outputs a to d
// RL3 - half-bridge: a carries pwm, b its complement, c and d unused
// RL4 - half-bridge output waits deadband instruction cycles before going active
// RL5 - deadband longer than active portion keeps that output inactive all period
// RL6 - full-bridge drives all four outputs
// RL7 - forward: a active, d modulated, b and c inactive
// RL8 - reverse: c active, b modulated, a and d inactive
// RL9 - single mode: outputs enabled only by steering enables
// RL10 - channel mode field sets active-high or active-low outputs
// RL11 - after enable no waveform until the next period begins
// RL12 - time base is 8-bit counter extended by two low prescale bits
// RL13 - control register all zeros releases the output pins
// RL14 - pins unused by the mode stay free for other functions
// RL15 - software must clear pin direction bits so waveform reaches pins; here the block drives pwm_oe_o itself
// RL16 - unimplemented control bits read as zero
// RL17 - after period match clear counter, set output unless zero duty, latch duty
// RL18 - output goes inactive when time base equals shadowed 10-bit duty
// RL19 - deadband applied separately to a and b rising edges
module pwm_bridge #(
  parameter DEADBAND_W = 7
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg pwm_out_a_o,
  output reg pwm_out_b_o,
  output reg pwm_out_c_o,
  output reg pwm_out_d_o,
  output reg [3:0] pwm_oe_o
);

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0] channel_control_reg;
  reg [7:0] duty_high_byte_reg;
  reg [7:0] period_limit_reg;
  reg [7:0] timer_control_reg;
  reg [7:0] period_counter_reg;
  reg [7:0] deadband_control_reg;
  reg [7:0] steering_reg;
  reg [7:0] duty_shadow_byte_reg;
  reg [1:0] duty_shadow_low_reg;
  reg [5:0] prescale_reg;
  reg started_reg;
  reg pwm_reg;
  reg [DEADBAND_W+1:0] dead_a_reg;
  reg [DEADBAND_W+1:0] dead_b_reg;

  wire [1:0] output_config_field = channel_control_reg[`CFG_HI:`CFG_LO];
  wire [3:0] channel_mode_field = channel_control_reg[`MODE_HI:`MODE_LO];
  wire [DEADBAND_W-1:0] deadband_count = deadband_control_reg[DEADBAND_W-1:0];
  wire timer_run_bit = timer_control_reg[`TRUN_BIT];
  wire [1:0] timer_prescale_select = timer_control_reg[`TPRE_HI:`TPRE_LO];
  wire pwm_enabled = (channel_mode_field[3:2] == 2'b11);
  wire wb_req = cyc_i & stb_i & ~ack_o;
  // writes land at the edge that sees ack high
  wire wb_write = cyc_i & stb_i & ack_o & we_i & sel_i[0];

  // ************************************************************
  // time base
  // ************************************************************
  // quarter count width for prescale 1, 4, 16
  function [5:0] prescale_top;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: prescale_top = 6'h03;
        2'b01: prescale_top = 6'h0f;
        default: prescale_top = 6'h3f;
      endcase
    end
  endfunction

  // two low time-base bits from the prescaler
  function [1:0] low_bits;
    input [1:0] sel;
    input [5:0] pre;
    begin
      case (sel)
        2'b00: low_bits = pre[1:0];
        2'b01: low_bits = pre[3:2];
        default: low_bits = pre[5:4];
      endcase
    end
  endfunction

  // wraps at once if the prescale select shrinks while counting
  wire prescale_wrap = (prescale_reg >= prescale_top(timer_prescale_select));
  wire period_end = timer_run_bit & prescale_wrap & (period_counter_reg == period_limit_reg);
  // RL12 time base
  wire [9:0] time_base = {period_counter_reg, low_bits(timer_prescale_select, prescale_reg)};
  wire [9:0] duty_value = {duty_shadow_byte_reg, duty_shadow_low_reg};
  wire [9:0] duty_buf = {duty_high_byte_reg, channel_control_reg[`DLOW_HI:`DLOW_LO]};
  // one instruction cycle is four clocks
  wire [DEADBAND_W+1:0] dead_cycles = {deadband_count, 2'b00};

  reg [5:0] prescale_next;
  reg [7:0] period_counter_next;
  always @*
  begin
    prescale_next = prescale_reg;
    period_counter_next = period_counter_reg;
    if (wb_write && adr_i == `ADDR_PERIOD_COUNTER)
    begin
      prescale_next = 6'h00;
      period_counter_next = dat_i[7:0];
    end
    else if (timer_run_bit)
    begin
      prescale_next = prescale_wrap ? 6'h00 : prescale_reg + 6'h01;
      // RL17 counter clear
      if (period_end)
        period_counter_next = `RST_ZERO;
      else if (prescale_wrap)
        period_counter_next = period_counter_reg + 8'h01;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prescale_reg <= 6'h00;
      period_counter_reg <= `RST_ZERO;
    end
    else
    begin
      prescale_reg <= prescale_next;
      period_counter_reg <= period_counter_next;
    end
  end

  // ************************************************************
  // modulator
  // ************************************************************
  reg started_next;
  reg pwm_next;
  reg [7:0] duty_shadow_byte_next;
  reg [1:0] duty_shadow_low_next;
  // RL18 inactive from the matching count on, so width equals duty
  wire duty_match = (time_base == duty_value);
  wire pwm_live = pwm_reg & ~duty_match;
  always @*
  begin
    started_next = started_reg;
    pwm_next = pwm_reg;
    duty_shadow_byte_next = duty_shadow_byte_reg;
    duty_shadow_low_next = duty_shadow_low_reg;
    // RL11 wait for period start
    if (!pwm_enabled)
      started_next = 1'b0;
    else if (period_end)
      started_next = 1'b1;
    if (period_end)
    begin
      // RL17 latch duty and set
      duty_shadow_byte_next = duty_high_byte_reg;
      duty_shadow_low_next = channel_control_reg[`DLOW_HI:`DLOW_LO];
      pwm_next = pwm_enabled && (duty_buf != 10'h000);
    end
    // RL18 clear on duty match
    else if (duty_match)
      pwm_next = 1'b0;
    if (!pwm_enabled)
      pwm_next = 1'b0;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      duty_shadow_byte_reg <= `RST_ZERO;
      duty_shadow_low_reg <= 2'b00;
      pwm_reg <= 1'b0;
      started_reg <= 1'b0;
    end
    else
    begin
      duty_shadow_byte_reg <= duty_shadow_byte_next;
      duty_shadow_low_reg <= duty_shadow_low_next;
      pwm_reg <= pwm_next;
      started_reg <= started_next;
    end
  end

  // ************************************************************
  // dead band
  // ************************************************************
  // RL4 RL19 separate rising delays
  reg [DEADBAND_W+1:0] dead_a_next;
  reg [DEADBAND_W+1:0] dead_b_next;
  always @*
  begin
    dead_a_next = dead_a_reg;
    dead_b_next = dead_b_reg;
    // RL5 never reaches active if too long
    if (!pwm_live)
      dead_a_next = {(DEADBAND_W+2){1'b0}};
    else if (dead_a_reg < dead_cycles)
      dead_a_next = dead_a_reg + 1'b1;
    if (pwm_live)
      dead_b_next = {(DEADBAND_W+2){1'b0}};
    else if (dead_b_reg < dead_cycles)
      dead_b_next = dead_b_reg + 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dead_a_reg <= {(DEADBAND_W+2){1'b0}};
      dead_b_reg <= {(DEADBAND_W+2){1'b0}};
    end
    else
    begin
      dead_a_reg <= dead_a_next;
      dead_b_reg <= dead_b_next;
    end
  end

  // compare as at-least so a shortened dead band cannot overrun
  wire half_a = pwm_live & (dead_a_reg >= dead_cycles);
  wire half_b = ~pwm_live & (dead_b_reg >= dead_cycles) & started_reg;

  // ************************************************************
  // output steering
  // ************************************************************
  reg [3:0] act_next;
  reg [3:0] oe_next;
  always @*
  begin
    act_next = 4'h0;
    oe_next = 4'h0;
    // RL1 mode select
    case (output_config_field)
      `OCFG_HALF:
      begin
        // RL3 complementary pair
        act_next = {2'b00, half_b, half_a};
        // RL14 c and d left free
        oe_next = 4'b0011;
      end
      `OCFG_FULL_FWD:
      begin
        // RL6 RL7 forward drive
        act_next = {pwm_live, 1'b0, 1'b0, started_reg};
        oe_next = 4'b1111;
      end
      `OCFG_FULL_REV:
      begin
        // RL8 reverse drive
        act_next = {1'b0, started_reg, pwm_live, 1'b0};
        oe_next = 4'b1111;
      end
      default:
      begin
        // RL9 steering enables
        act_next = {4{pwm_live}} & steering_reg[3:0];
        oe_next = steering_reg[3:0];
      end
    endcase
    // RL13 release pins
    if (!pwm_enabled)
    begin
      act_next = 4'h0;
      oe_next = 4'h0;
    end
  end

  // RL10 polarity: bit0 low for b/d, bit1 low for a/c
  wire [3:0] pol = {channel_mode_field[0], channel_mode_field[1],
                    channel_mode_field[0], channel_mode_field[1]};

  // RL2 four output pins
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_out_a_o <= 1'b0;
      pwm_out_b_o <= 1'b0;
      pwm_out_c_o <= 1'b0;
      pwm_out_d_o <= 1'b0;
      pwm_oe_o <= 4'h0;
    end
    else
    begin
      pwm_out_a_o <= act_next[0] ^ pol[0];
      pwm_out_b_o <= act_next[1] ^ pol[1];
      pwm_out_c_o <= act_next[2] ^ pol[2];
      pwm_out_d_o <= act_next[3] ^ pol[3];
      pwm_oe_o <= oe_next;
    end
  end

  // ************************************************************
  // wishbone slave
  // ************************************************************
  reg [7:0] channel_control_next;
  reg [7:0] duty_high_byte_next;
  reg [7:0] period_limit_next;
  reg [7:0] timer_control_next;
  reg [7:0] deadband_control_next;
  reg [7:0] steering_next;
  always @*
  begin
    channel_control_next = channel_control_reg;
    duty_high_byte_next = duty_high_byte_reg;
    period_limit_next = period_limit_reg;
    timer_control_next = timer_control_reg;
    deadband_control_next = deadband_control_reg;
    steering_next = steering_reg;
    // unmapped or read-only index: write ignored
    if (wb_write)
    begin
      case (adr_i)
        `ADDR_CHANNEL_CONTROL: channel_control_next = dat_i[7:0];
        `ADDR_DUTY_HIGH: duty_high_byte_next = dat_i[7:0];
        `ADDR_PERIOD_LIMIT: period_limit_next = dat_i[7:0];
        `ADDR_TIMER_CONTROL: timer_control_next = dat_i[7:0] & `TIMER_CONTROL_MASK;
        `ADDR_DEADBAND_CONTROL: deadband_control_next = {1'b0, dat_i[6:0]};
        `ADDR_STEERING: steering_next = dat_i[7:0] & `STEERING_MASK;
        default: ;
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_control_reg <= `RST_CHANNEL_CONTROL;
      duty_high_byte_reg <= `RST_ZERO;
      period_limit_reg <= `RST_PERIOD_LIMIT;
      timer_control_reg <= `RST_ZERO;
      deadband_control_reg <= `RST_ZERO;
      steering_reg <= `RST_STEERING;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= wb_req;
      channel_control_reg <= channel_control_next;
      duty_high_byte_reg <= duty_high_byte_next;
      period_limit_reg <= period_limit_next;
      timer_control_reg <= timer_control_next;
      deadband_control_reg <= deadband_control_next;
      steering_reg <= steering_next;
      // RL16 unimplemented reads zero
      dat_o <= 32'h00000000;
      if (wb_req && !we_i)
      begin
        case (adr_i)
          `ADDR_CHANNEL_CONTROL: dat_o[7:0] <= channel_control_reg;
          `ADDR_DUTY_HIGH: dat_o[7:0] <= duty_high_byte_reg;
          `ADDR_PERIOD_LIMIT: dat_o[7:0] <= period_limit_reg;
          `ADDR_TIMER_CONTROL: dat_o[7:0] <= timer_control_reg;
          `ADDR_PERIOD_COUNTER: dat_o[7:0] <= period_counter_reg;
          `ADDR_DEADBAND_CONTROL: dat_o[7:0] <= deadband_control_reg;
          `ADDR_STEERING: dat_o[7:0] <= steering_reg;
          `ADDR_DUTY_SHADOW: dat_o[7:0] <= duty_shadow_byte_reg;
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // pwm_bridge

// *** pwm_bridge_defines.vh ***
// register map, field positions and reset values for the enhanced bridge pwm
`ifndef PWM_BRIDGE_DEFINES_VH
`define PWM_BRIDGE_DEFINES_VH
// word byte addresses
`define ADDR_CHANNEL_CONTROL 4'h0
`define ADDR_DUTY_HIGH 4'h1
`define ADDR_PERIOD_LIMIT 4'h2
`define ADDR_TIMER_CONTROL 4'h3
`define ADDR_PERIOD_COUNTER 4'h4
`define ADDR_DEADBAND_CONTROL 4'h5
`define ADDR_STEERING 4'h6
`define ADDR_DUTY_SHADOW 4'h7
// channel control fields
`define CFG_HI 7
`define CFG_LO 6
`define DLOW_HI 5
`define DLOW_LO 4
`define MODE_HI 3
`define MODE_LO 0
// output configurations
`define OCFG_SINGLE 2'b00
`define OCFG_FULL_FWD 2'b01
`define OCFG_HALF 2'b10
`define OCFG_FULL_REV 2'b11
// timer control fields
`define TRUN_BIT 2
`define TPRE_HI 1
`define TPRE_LO 0
`define TIMER_CONTROL_MASK 8'h07
// reset values and steering write mask
`define RST_CHANNEL_CONTROL 8'h00
`define RST_PERIOD_LIMIT 8'hff
`define RST_ZERO 8'h00
`define RST_STEERING 8'h01
`define STEERING_MASK 8'h0f
// oscillator periods per instruction cycle
`define OSC_PER_INSTR 4
`endif

// *** pwm_bridge_chk.sv ***
// port checker for the bridge pwm block
`timescale 1ns/10ps
module pwm_bridge_chk #(
  parameter DEADBAND_W = 7
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire pwm_out_a_o,
  input wire pwm_out_b_o,
  input wire pwm_out_c_o,
  input wire pwm_out_d_o,
  input wire [3:0] pwm_oe_o
);
  // ****************************************
  // control mirror, steady for two cycles
  // ****************************************
  reg [7:0] m0_reg;
  reg [7:0] m1_reg;
  reg [7:0] m2_reg;
  wire held = (m0_reg == m1_reg) && (m1_reg == m2_reg);
  wire [1:0] cfg = m0_reg[7:6];
  wire hi = held && (m0_reg[3:0] == 4'hc);
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      m0_reg <= 8'h00;
      m1_reg <= 8'h00;
      m2_reg <= 8'h00;
    end
    else
    begin
      if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 4'h0)
        m0_reg <= dat_i[7:0];
      m1_reg <= m0_reg;
      m2_reg <= m1_reg;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
  property p_hi0; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  property p_half; hi && cfg == 2'b10 |-> !(pwm_out_a_o && pwm_out_b_o); endproperty
  a_half: assert property (p_half) else $error("a and b active together");
  property p_cd; held && cfg == 2'b10 && m0_reg[3:2] == 2'b11 |-> pwm_oe_o[3:2] == 2'b00;
  endproperty
  a_cd: assert property (p_cd) else $error("c or d driven in half mode");
  property p_fwd; hi && cfg == 2'b01 |-> !pwm_out_b_o && !pwm_out_c_o; endproperty
  a_fwd: assert property (p_fwd) else $error("b or c active in forward");
  property p_rev; hi && cfg == 2'b11 |-> !pwm_out_a_o && !pwm_out_d_o; endproperty
  a_rev: assert property (p_rev) else $error("a or d active in reverse");
  property p_full; held && cfg[0] && m0_reg[3:2] == 2'b11 |-> pwm_oe_o == 4'hf; endproperty
  a_full: assert property (p_full) else $error("full bridge not driving all");
  property p_rel; held && m0_reg == 8'h00 |-> pwm_oe_o == 4'h0 && !pwm_out_a_o; endproperty
  a_rel: assert property (p_rel) else $error("pins not released");
  c_half: cover property (hi && cfg == 2'b10 && pwm_out_b_o);
  c_fwd: cover property (hi && cfg == 2'b01 && pwm_out_d_o);
  c_rev: cover property (hi && cfg == 2'b11 && pwm_out_b_o);
endmodule // pwm_bridge_chk
bind pwm_bridge pwm_bridge_chk #(.DEADBAND_W(DEADBAND_W)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .pwm_out_a_o(pwm_out_a_o),
  .pwm_out_b_o(pwm_out_b_o), .pwm_out_c_o(pwm_out_c_o), .pwm_out_d_o(pwm_out_d_o),
  .pwm_oe_o(pwm_oe_o)
);

// *** bridge_driver_model.sv ***
// load model of the external bridge switch drivers
`timescale 1ns/10ps
module bridge_driver_model (
  input wire clk_i,
  input wire clr_i,
  input wire [3:0] pin_i,
  input wire [3:0] oe_i,
  output reg [31:0] on_cnt_o,
  output reg shoot_o
);
  wire [3:0] seen = pin_i & oe_i;
  always @(posedge clk_i)
  begin
    if (clr_i)
    begin
      on_cnt_o <= 32'h0;
      shoot_o <= 1'b0;
    end
    else
    begin
      on_cnt_o <= on_cnt_o + {7'h0, seen[3], 7'h0, seen[2], 7'h0, seen[1], 7'h0, seen[0]};
      if (seen[0] && seen[1])
        shoot_o <= 1'b1;
    end
  end
endmodule // bridge_driver_model

// *** testbench.sv ***
// self-checking bench for the bridge pwm block
`timescale 1ns/10ps
`include "pwm_bridge_defines.vh"
module testbench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, clr, shoot;
  logic pa, pb, pc, pd;
  logic [3:0] adr_i, sel_i, pwm_oe_o;
  logic [31:0] dat_i, dat_o, cnt, q;
  integer failures, comparisons;
  integer ticks = 0;
  pwm_bridge i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .pwm_out_a_o(pa), .pwm_out_b_o(pb), .pwm_out_c_o(pc), .pwm_out_d_o(pd),
    .pwm_oe_o(pwm_oe_o));
  bridge_driver_model i_load (.clk_i(clk_i), .clr_i(clr), .pin_i({pd, pc, pb, pa}),
    .oe_i(pwm_oe_o), .on_cnt_o(cnt), .shoot_o(shoot));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task wrap_up;
  begin
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  always @(posedge clk_i)
  begin
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      failures = failures + 1;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // one classic cycle, called just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s);
    integer n;
  begin
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= {3'h0, s};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge clk_i);
    end
    if (n == 50)
      failures = failures + 1;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
  begin
    wb(1'b0, a, 8'h00, 1'b1);
    chk(q, exp);
  end
  endtask
  // set mode, settle, then count driven-high cycles over four 16-clock periods
  task automatic win(input logic [7:0] ctl, input logic [31:0] exp);
  begin
    wb(1'b1, `ADDR_CHANNEL_CONTROL, ctl, 1'b1);
    repeat (48) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (64) @(posedge clk_i);
    #1;
    chk(cnt, exp);
    chk({31'h0, shoot}, 32'h0);
  end
  endtask
  initial
  begin
    failures = 0;
    comparisons = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    dat_i = 32'h0;
    sel_i = 4'h0;
    clr = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ADDR_CHANNEL_CONTROL, 32'h0);
    rd(`ADDR_PERIOD_LIMIT, 32'hff);
    rd(`ADDR_STEERING, 32'h01);
    rd(4'h9, 32'h0);
    wb(1'b1, `ADDR_DEADBAND_CONTROL, 8'hff, 1'b1);
    rd(`ADDR_DEADBAND_CONTROL, 32'h7f);
    wb(1'b1, `ADDR_TIMER_CONTROL, 8'hff, 1'b1);
    rd(`ADDR_TIMER_CONTROL, 32'h07);
    wb(1'b1, `ADDR_PERIOD_LIMIT, 8'h03, 1'b0);
    rd(`ADDR_PERIOD_LIMIT, 32'hff);
    wb(1'b1, `ADDR_PERIOD_LIMIT, 8'h03, 1'b1);
    wb(1'b1, `ADDR_DUTY_HIGH, 8'h01, 1'b1);
    wb(1'b1, `ADDR_TIMER_CONTROL, 8'h04, 1'b1);
    wb(1'b1, `ADDR_DEADBAND_CONTROL, 8'h01, 1'b1);
    win(8'h2c, 32'h00000018);
    rd(`ADDR_DUTY_SHADOW, 32'h01);
    win(8'h2e, 32'h00000028);
    win(8'hac, 32'h00001808);
    wb(1'b1, `ADDR_DEADBAND_CONTROL, 8'h02, 1'b1);
    win(8'hac, 32'h00000800);
    win(8'h6c, 32'h18000040);
    win(8'hec, 32'h00401800);
    wb(1'b1, `ADDR_STEERING, 8'hff, 1'b1);
    rd(`ADDR_STEERING, 32'h0f);
    wb(1'b1, `ADDR_STEERING, 8'h0d, 1'b1);
    win(8'h2c, 32'h18180018);
    wb(1'b1, `ADDR_DUTY_HIGH, 8'h00, 1'b1);
    win(8'h0c, 32'h00000000);
    win(8'h00, 32'h00000000);
    chk({28'h0, pwm_oe_o}, 32'h0);
    wrap_up;
  end
endmodule // testbench
